// [dbe_event_logic.sv]
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
// Operation
// R1: halt instruction halts only if connected and permitted
// R2: 64-bit break instruction raises exception, never halts
// R3: breakpoint comparator matches instruction address
// R4: halted core stops fetching, debugger drives it
// R5: monitor mode raises debug exception, no halt
// R6: each event gets exactly one action; here only one per cycle is converted, none while a halt is pended
// R7: never both exception and debug state
// R8: control register selects monitor or halting mode
// R9: secure state with untrusted debugger blocks halting
// R10: all event sources are synchronous to instruction
// R11: bp/wp exceptions only when enabled here
// R12: software step only while exceptions enabled
// R13: break instruction exception cannot be masked; here a break raises none while a halt is pended
// R14: context breakpoint matches context id or vm id
// R15: breakpoints qualified by level, security; linkable
// R16: watchpoints compare data addresses, qualified, linkable
// R17: watchpoint access type selects loads, stores, both
// R18: watchpoints never match instruction fetches
// R19: unit counts readable in identification register
// R20: debugger software restores patched opcodes itself
// R21: pended event held until allowed, then converted
module dbe_event_logic import dbe_pkg::*; (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // retiring instruction
  input wire logic instValid,
  input wire logic [31:0] instAddr,
  input wire logic instIsHalt,
  input wire logic instIsBreak,
  input wire logic instIs64,
  // data access
  input wire logic dataValid,
  input wire logic [31:0] dataAddr,
  input wire logic dataIsStore,
  input wire logic dataIsFetch,
  // core context
  input wire logic [1:0] curEl,
  input wire logic curSecure,
  input wire logic [31:0] contextId,
  input wire logic [7:0] virtualMachineId,
  // debugger pins, asynchronous
  input wire logic dbgConnectedPin,
  input wire logic dbgTrustedPin,
  // actions
  output logic debugException,
  output logic [1:0] excTargetEl,
  output logic enterDebugState,
  output logic eventIgnored,
  output logic eventPending,
  output logic fetchStop
);
  logic [31:0] ctrlReg;
  logic [31:0] bpCtrl [NUM_BP];
  logic [31:0] bpValue [NUM_BP];
  logic [31:0] wpCtrl [NUM_WP];
  logic [31:0] wpValue [NUM_WP];
  logic [NUM_BP-1:0] bpAddrHit;
  logic [NUM_BP-1:0] bpCtxHit;
  logic [NUM_BP-1:0] bpEvent;
  logic [NUM_WP-1:0] wpAddrHit;
  logic [NUM_WP-1:0] wpEvent;
  logic connMeta, connSync, trustMeta, trustSync;
  logic stepArmed;
  dbe_state_t state, next_state;
  dbe_act_t lastAct, next_act;
  logic next_pend;
  logic haltAllowed;
  logic hwEvent, stepEvent, haltEvent, breakEvent;
  logic busWrite, restartReq;
  logic [7:0] unitOfs;
  logic [31:0] wmask;

  // debugger pins cross in through two flops each
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      connMeta <= 1'b0;
      connSync <= 1'b0;
      trustMeta <= 1'b0;
      trustSync <= 1'b0;
    end else if (ce) begin
      connMeta <= dbgConnectedPin;
      connSync <= connMeta;
      trustMeta <= dbgTrustedPin;
      trustSync <= trustMeta;
    end
  end

  // byte lanes to bit mask
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign busWrite = ce & wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign unitOfs = wb_adr_i & 8'h3F;
  assign restartReq = busWrite & (wb_adr_i == OFS_CTRL) & wb_sel_i[0]
    & wb_dat_i[CTRL_RESTART];

  // control register; restart is a self-clearing strobe, not stored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrlReg <= CTRL_RST;
    end else if (busWrite && wb_adr_i == OFS_CTRL) begin
      ctrlReg <= (ctrlReg & ~(wmask & CTRL_WMASK)) | (wb_dat_i & wmask & CTRL_WMASK); // R8
    end
  end

  // comparator units, one per breakpoint and watchpoint
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BP; gi++) begin : g_bp
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          bpCtrl[gi] <= UNIT_RST;
          bpValue[gi] <= UNIT_RST;
        end else if (busWrite && wb_adr_i[7:6] == OFS_BP_BASE[7:6]
            && unitOfs[7:3] == 5'(gi)) begin
          if (unitOfs[2]) begin
            bpCtrl[gi] <= (bpCtrl[gi] & ~wmask) | (wb_dat_i & wmask);
          end else begin
            bpValue[gi] <= (bpValue[gi] & ~wmask) | (wb_dat_i & wmask);
          end
        end
      end
      dbe_match_unit u_bp (
        .unitCtrl(bpCtrl[gi]),
        .unitValue(bpValue[gi]),
        .isWatch(1'b0),
        .sampleValid(instValid),
        .sampleAddr(instAddr),
        .accStore(1'b0),
        .accFetch(1'b1),
        .contextId(contextId),
        .virtualMachineId(virtualMachineId),
        .curEl(curEl),
        .curSecure(curSecure),
        .addrHit(bpAddrHit[gi]),
        .ctxHit(bpCtxHit[gi])
      );
      // address hit gated by its linked context unit; a context unit with
      // its link bit set serves only as a link target
      assign bpEvent[gi] = (bpAddrHit[gi] & (~bpCtrl[gi][UC_LINK]
          | bpCtxHit[bpCtrl[gi][UC_LINK_IDX]]))
        | (bpCtxHit[gi] & instValid & ~bpCtrl[gi][UC_LINK]); // R15 R14
    end
    for (gi = 0; gi < NUM_WP; gi++) begin : g_wp
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          wpCtrl[gi] <= UNIT_RST;
          wpValue[gi] <= UNIT_RST;
        end else if (busWrite && wb_adr_i[7:6] == OFS_WP_BASE[7:6]
            && unitOfs[7:3] == 5'(gi)) begin
          if (unitOfs[2]) begin
            wpCtrl[gi] <= (wpCtrl[gi] & ~wmask) | (wb_dat_i & wmask);
          end else begin
            wpValue[gi] <= (wpValue[gi] & ~wmask) | (wb_dat_i & wmask);
          end
        end
      end
      dbe_match_unit u_wp (
        .unitCtrl(wpCtrl[gi]),
        .unitValue(wpValue[gi]),
        .isWatch(1'b1),
        .sampleValid(dataValid),
        .sampleAddr(dataAddr),
        .accStore(dataIsStore),
        .accFetch(dataIsFetch),
        .contextId(contextId),
        .virtualMachineId(virtualMachineId),
        .curEl(curEl),
        .curSecure(curSecure),
        .addrHit(wpAddrHit[gi]),
        .ctxHit()
      );
      assign wpEvent[gi] = wpAddrHit[gi] & (~wpCtrl[gi][UC_LINK]
        | bpCtxHit[wpCtrl[gi][UC_LINK_IDX]]); // R16
    end
  endgenerate

  // event sources, all tied to the retiring instruction or access
  assign hwEvent = (|bpEvent) | (|wpEvent); // R10
  assign haltEvent = instValid & instIsHalt; // R10
  assign breakEvent = instValid & instIsBreak & instIs64; // R10
  assign stepEvent = stepArmed & instValid & ctrlReg[CTRL_EXC_EN]; // R12
  // halting needs a debugger and must not expose secure state
  assign haltAllowed = connSync & ~(curSecure & ~trustSync); // R9

  // step arms after one instruction, fires on the next
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stepArmed <= 1'b0;
    end else if (ce) begin
      if (!ctrlReg[CTRL_STEP_EN] || !ctrlReg[CTRL_EXC_EN] || state == ST_HALTED) begin
        stepArmed <= 1'b0; // R12
      end else if (instValid) begin
        stepArmed <= 1'b1;
      end
    end
  end

  // conversion: one action per cycle, pending held aside
  always_comb begin
    next_act = ACT_NONE;
    next_pend = eventPending;
    next_state = state;
    case (state)
      ST_RUN: begin
        if (eventPending) begin
          if (haltAllowed) begin
            next_act = ACT_HALT; // R21
            next_pend = 1'b0;
          end
        end else if (breakEvent) begin
          next_act = ACT_EXC; // R2 R13
        end else if (haltEvent) begin
          if (haltAllowed) begin
            next_act = ACT_HALT; // R1
          end else if (connSync) begin
            next_pend = 1'b1; // R9 R21
          end else begin
            next_act = ACT_IGNORE;
          end
        end else if (hwEvent) begin
          if (ctrlReg[CTRL_HALT_MODE] && connSync) begin
            if (haltAllowed) begin
              next_act = ACT_HALT; // R8
            end else begin
              next_pend = 1'b1; // R9 R21
            end
          end else if (ctrlReg[CTRL_EXC_EN]) begin
            next_act = ACT_EXC; // R5 R11
          end else begin
            next_act = ACT_IGNORE; // R11
          end
        end else if (stepEvent) begin
          next_act = ACT_EXC; // R12
        end
        if (next_act == ACT_HALT) begin
          next_state = ST_HALTED;
        end
      end
      ST_HALTED: begin
        if (restartReq) begin
          next_state = ST_RUN; // R4
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // exception, halt and ignore outputs are registered single-cycle pulses
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_RUN;
      lastAct <= ACT_NONE;
      eventPending <= 1'b0;
      debugException <= 1'b0;
      enterDebugState <= 1'b0;
      eventIgnored <= 1'b0;
      excTargetEl <= 2'b00;
    end else if (ce) begin
      state <= next_state;
      eventPending <= next_pend; // R21
      debugException <= (next_act == ACT_EXC); // R6 R7
      enterDebugState <= (next_act == ACT_HALT); // R6 R7
      eventIgnored <= (next_act == ACT_IGNORE); // R6
      if (next_act != ACT_NONE) begin
        lastAct <= next_act;
      end
      if (next_act == ACT_EXC) begin
        excTargetEl <= ctrlReg[CTRL_TGT_EL +: 2]; // R11
      end
    end
  end
  assign fetchStop = (state == ST_HALTED); // R4

  // wishbone answer one cycle after the strobe, reads of holes are zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (wb_adr_i == OFS_CTRL) begin
        wb_dat_o <= ctrlReg;
      end else if (wb_adr_i == OFS_ID) begin
        wb_dat_o[ID_BP +: 4] <= 4'(NUM_BP); // R19
        wb_dat_o[ID_WP +: 4] <= 4'(NUM_WP); // R19
      end else if (wb_adr_i == OFS_STAT) begin
        wb_dat_o[STAT_HALTED] <= fetchStop;
        wb_dat_o[STAT_PEND] <= eventPending;
        wb_dat_o[STAT_LAST_ACT +: 2] <= lastAct;
      end else if (wb_adr_i[7:6] == OFS_BP_BASE[7:6] && unitOfs[7:3] < 5'(NUM_BP)) begin
        wb_dat_o <= unitOfs[2] ? bpCtrl[unitOfs[3]] : bpValue[unitOfs[3]];
      end else if (wb_adr_i[7:6] == OFS_WP_BASE[7:6] && unitOfs[7:3] < 5'(NUM_WP)) begin
        wb_dat_o <= unitOfs[2] ? wpCtrl[unitOfs[3]] : wpValue[unitOfs[3]];
      end
    end
  end

  // checks beside the logic
  AST_ONE_ACTION: assert property (@(posedge clk_sys) disable iff (rst) // R7
    $onehot0({debugException, enterDebugState, eventIgnored}))
    else $error("more than one action at once");
  AST_HALT_BLOCKED: assert property (@(posedge clk_sys) disable iff (rst) // R9
    ce && curSecure && !trustSync |=> !enterDebugState)
    else $error("halt entered while secure and untrusted");
  AST_BREAK_EXC: assert property (@(posedge clk_sys) disable iff (rst) // R13
    ce && state == ST_RUN && !eventPending && breakEvent |=> debugException && !enterDebugState)
    else $error("break instruction did not raise exception");
  AST_HALT_INST: assert property (@(posedge clk_sys) disable iff (rst) // R1
    ce && state == ST_RUN && !eventPending && instValid && instIsHalt && !instIsBreak
      && haltAllowed |=> enterDebugState ##1 fetchStop)
    else $error("halt instruction did not enter debug state");
  AST_STAY_HALTED: assert property (@(posedge clk_sys) disable iff (rst) // R4
    fetchStop && !restartReq |=> fetchStop)
    else $error("left debug state without restart");
  AST_NO_EXC_HALTED: assert property (@(posedge clk_sys) disable iff (rst) // R4
    fetchStop && $past(fetchStop) |-> !debugException && !enterDebugState)
    else $error("action while halted");
  AST_MONITOR: assert property (@(posedge clk_sys) disable iff (rst) // R5
    ce && state == ST_RUN && !eventPending && !instValid && hwEvent
      && !ctrlReg[CTRL_HALT_MODE] && ctrlReg[CTRL_EXC_EN] |=> debugException)
    else $error("monitor mode event gave no exception");
  // with exceptions off only the unmaskable break may raise one, so a step cannot
  AST_STEP_GATED: assert property (@(posedge clk_sys) disable iff (rst) // R12
    ce && !ctrlReg[CTRL_EXC_EN] && !breakEvent |=> !debugException)
    else $error("exception raised with exceptions disabled");
  AST_PEND_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // R21
    ce && eventPending && !haltAllowed |=> eventPending && !enterDebugState)
    else $error("pended event lost or converted early");
  AST_PEND_CONV: assert property (@(posedge clk_sys) disable iff (rst) // R21
    ce && eventPending && haltAllowed && state == ST_RUN |=> !eventPending && enterDebugState)
    else $error("pended event not converted");
  AST_WP_FETCH: assert property (@(posedge clk_sys) disable iff (rst) // R18
    dataIsFetch |-> wpAddrHit == '0)
    else $error("watchpoint matched a fetch");
endmodule : dbe_event_logic

// [dbe_pkg.sv]
package dbe_pkg;
  // unit counts, reported through the identification register
  localparam int NUM_BP = 2;
  localparam int NUM_WP = 2;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ID = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_BP_BASE = 8'h40;
  localparam logic [7:0] OFS_WP_BASE = 8'h80;
  localparam int UNIT_STRIDE = 8;
  localparam int UNIT_CTRL_OFS = 4;
  // ext_debug_status_control fields
  localparam int CTRL_HALT_MODE = 0;
  localparam int CTRL_EXC_EN = 1;
  localparam int CTRL_STEP_EN = 2;
  localparam int CTRL_RESTART = 3;
  localparam int CTRL_TGT_EL = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0037;
  // status fields
  localparam int STAT_HALTED = 0;
  localparam int STAT_PEND = 1;
  localparam int STAT_LAST_ACT = 4;
  // identification fields
  localparam int ID_BP = 0;
  localparam int ID_WP = 4;
  // per-unit control fields
  localparam int UC_EN = 0;
  localparam int UC_CTX = 1;
  localparam int UC_VIRTUAL_MACHINE_ID = 2;
  localparam int UC_LINK = 3;
  localparam int UC_LINK_IDX = 4;
  localparam int UC_EL = 8;
  localparam int UC_NS = 12;
  localparam int UC_S = 13;
  localparam int UC_LOAD = 14;
  localparam int UC_STORE = 15;
  localparam logic [31:0] UNIT_RST = 32'h0000_0000;
  // conversion result of one event
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_EXC = 2'b01,
    ACT_HALT = 2'b10,
    ACT_IGNORE = 2'b11
  } dbe_act_t;
  // core run state
  typedef enum logic {
    ST_RUN = 1'b0,
    ST_HALTED = 1'b1
  } dbe_state_t;
endpackage : dbe_pkg

// [dbe_match_unit.sv]
`timescale 1ns/1ps
module dbe_match_unit import dbe_pkg::*; (
  // programmed unit
  input wire logic [31:0] unitCtrl,
  input wire logic [31:0] unitValue,
  input wire logic isWatch,
  // sampled access and context
  input wire logic sampleValid,
  input wire logic [31:0] sampleAddr,
  input wire logic accStore,
  input wire logic accFetch,
  input wire logic [31:0] contextId,
  input wire logic [7:0] virtualMachineId,
  input wire logic [1:0] curEl,
  input wire logic curSecure,
  // results
  output logic addrHit,
  output logic ctxHit
);
  logic qualified;
  logic accessOk;
  logic [31:0] ctxValue;

  // mode, level and security qualification
  assign qualified = unitCtrl[UC_EN] & unitCtrl[UC_EL + curEl]
    & (curSecure ? unitCtrl[UC_S] : unitCtrl[UC_NS]); // R15 R16
  // vm id only means something in non-secure state
  assign ctxValue = (unitCtrl[UC_VIRTUAL_MACHINE_ID] & ~curSecure) ? {24'h00_0000, virtualMachineId}
    : contextId; // R14
  // watchpoints never see fetches and filter on access type
  assign accessOk = ~isWatch
    | (~accFetch & (accStore ? unitCtrl[UC_STORE] : unitCtrl[UC_LOAD])); // R17 R18
  assign addrHit = qualified & sampleValid & ~unitCtrl[UC_CTX] & accessOk
    & (unitValue == sampleAddr); // R3 R16
  assign ctxHit = qualified & unitCtrl[UC_CTX] & ~isWatch & (unitValue == ctxValue); // R14
endmodule : dbe_match_unit

// [dbe_debugger_model.sv]
`timescale 1ns/1ps
module dbe_debugger_model (
  // clock
  input wire logic clk_sys,
  // core side
  input wire logic enterDebugState,
  // debugger pins
  output logic dbgConnectedPin,
  output logic dbgTrustedPin
);
  logic [31:0] patchAddr;
  logic [31:0] patchOpcode;
  int haltsSeen;
  // start detached, so no halt is granted before the bench attaches
  initial begin
    dbgConnectedPin = 1'b0;
    dbgTrustedPin = 1'b0;
    patchAddr = 32'h0000_0000;
    patchOpcode = 32'h0000_0000;
    haltsSeen = 0;
  end
  // attach or detach just after an edge; the pins are asynchronous anyway
  task automatic set_pins(input logic conn, input logic trust);
    @(posedge clk_sys);
    dbgConnectedPin <= conn;
    dbgTrustedPin <= trust;
  endtask : set_pins
  // a patched place is remembered with its opcode so it can be put back
  task automatic patch(input logic [31:0] addr, input logic [31:0] opcode);
    patchAddr = addr;
    patchOpcode = opcode;
  endtask : patch
  task automatic unpatch(output logic [31:0] addr, output logic [31:0] opcode);
    addr = patchAddr;
    opcode = patchOpcode;
  endtask : unpatch
  // count halt entries while attached
  always @(posedge clk_sys) begin
    if (enterDebugState === 1'b1 && dbgConnectedPin === 1'b1) begin
      haltsSeen <= haltsSeen + 1;
    end
  end
endmodule : dbe_debugger_model

// [debug_event_logic_bench.sv]
`timescale 1ns/1ps
module debug_event_logic_bench import dbe_pkg::*; ();
  localparam logic [31:0] BP_ADDR = 32'h0000_2000;
  localparam logic [31:0] WP_ADDR = 32'h0000_3000;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [5:0] cond;
    logic [3:0] act;
  } dbe_row_t;
  logic clk_sys, rst, ce, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, instAddr, dataAddr, contextId, rd, pa, po;
  logic wb_ack_o, instValid, instIsHalt, instIsBreak, instIs64;
  logic dataValid, dataIsStore, dataIsFetch, curSecure, dbgConnectedPin, dbgTrustedPin;
  logic [1:0] curEl, excTargetEl;
  logic [7:0] virtualMachineId;
  logic debugException, enterDebugState, eventIgnored, eventPending, fetchStop, seen;
  logic [3:0] acts;
  int mismatches, checked;
  // cond is {connected, trusted, secure, halt, break, bp hit}; act is {exc, halt, ign, pend}
  dbe_row_t rows [10] = '{{32'h0000_0032, 6'b000010, 4'h8}, {32'h0000_0003, 6'b110010, 4'h8},
    {32'h0000_0000, 6'b000010, 4'h8}, {32'h0000_0001, 6'b111100, 4'h4},
    {32'h0000_0001, 6'b000100, 4'h2}, {32'h0000_0022, 6'b000001, 4'h8},
    {32'h0000_0003, 6'b100001, 4'h4}, {32'h0000_0000, 6'b000001, 4'h2},
    {32'h0000_0003, 6'b000001, 4'h8}, {32'h0000_0001, 6'b101100, 4'h1}};
  dbe_event_logic dut_u (.clk_sys, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .instValid, .instAddr, .instIsHalt,
    .instIsBreak, .instIs64, .dataValid, .dataAddr, .dataIsStore, .dataIsFetch, .curEl,
    .curSecure, .contextId, .virtualMachineId, .dbgConnectedPin, .dbgTrustedPin,
    .debugException, .excTargetEl, .enterDebugState, .eventIgnored, .eventPending, .fetchStop);
  dbe_debugger_model dbg_u (.clk_sys, .enterDebugState, .dbgConnectedPin, .dbgTrustedPin);
  // free-running system clock
  always #5 clk_sys = ~clk_sys;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=0x%h exp=0x%h", $time, got, exp);
    end
  endtask : check
  // classic cycle; ack and read data are taken at the edge that samples ack high,
  // the request is released right after that same edge
  task automatic wb_rw(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    while (wb_ack_o !== 1'b1) begin
      if (n == 50) begin
        mismatches++;
        report_and_stop();
      end
      @(posedge clk_sys);
      n++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_rw
  // one retiring instruction or data access; the action registers one edge later
  task automatic fire(input logic h, input logic b, input logic hit, input logic dv,
    input logic st, input logic fe, output logic [3:0] a);
    @(posedge clk_sys);
    instValid <= ~dv;
    instIsHalt <= h;
    instIsBreak <= b;
    instAddr <= hit ? BP_ADDR : 32'h0000_1000;
    dataValid <= dv;
    dataIsStore <= st;
    dataIsFetch <= fe;
    dataAddr <= WP_ADDR;
    @(posedge clk_sys);
    instValid <= 1'b0;
    dataValid <= 1'b0;
    #1;
    a = {debugException, enterDebugState, eventIgnored, eventPending};
  endtask : fire
  // leave debug state; write lands at the edge that takes it
  task automatic restart();
    wb_rw(1'b1, OFS_CTRL, 32'h0000_0008, rd);
    @(posedge clk_sys);
    #1;
    check(32'(fetchStop), 32'h0000_0000);
  endtask : restart
  initial begin
    {clk_sys, wb_cyc_i, wb_stb_i, wb_we_i, instValid, instIsHalt, instIsBreak} = '0;
    {dataValid, dataIsStore, dataIsFetch, curSecure} = '0;
    {wb_adr_i, wb_dat_i, instAddr, dataAddr, contextId, virtualMachineId} = '0;
    {mismatches, checked} = '0;
    rst = 1'b1;
    ce = 1'b1;
    wb_sel_i = 4'hf;
    instIs64 = 1'b1;
    curEl = 2'b01;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    // reset values, masked and read-only places, an unmapped address
    wb_rw(1'b0, OFS_CTRL, 32'h0000_0000, rd);
    check(rd, CTRL_RST);
    check(32'({fetchStop, eventPending}), 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      wb_rw(1'b1, k == 0 ? OFS_CTRL : (k == 1 ? OFS_ID : 8'hf0), 32'hffff_fff7, rd);
    end
    for (int k = 0; k < 4; k++) begin
      wb_rw(1'b0, 8'(k * 4) | (k == 3 ? 8'hf0 : 8'h00), 32'h0000_0000, rd);
      check(rd, k == 0 ? 32'h0000_0037 : (k == 1 ? 32'(NUM_WP * 16 + NUM_BP) : 32'h0));
    end
    $display("register test done");
    // program bp0 on all levels and both states, wp0 for loads only
    wb_rw(1'b1, OFS_BP_BASE, BP_ADDR, rd);
    wb_rw(1'b1, OFS_BP_BASE + 8'(UNIT_CTRL_OFS), 32'h0000_3f01, rd);
    wb_rw(1'b1, OFS_WP_BASE, WP_ADDR, rd);
    wb_rw(1'b1, OFS_WP_BASE + 8'(UNIT_CTRL_OFS), 32'h0000_7f01, rd);
    for (int i = 0; i < 10; i++) begin
      wb_rw(1'b1, OFS_CTRL, rows[i].ctrl, rd);
      dbg_u.set_pins(rows[i].cond[5], rows[i].cond[4]);
      curSecure <= rows[i].cond[3];
      repeat (4) @(posedge clk_sys);
      fire(rows[i].cond[2], rows[i].cond[1], rows[i].cond[0], 1'b0, 1'b0, 1'b0, acts);
      check(32'(acts), 32'(rows[i].act));
      if (rows[i].act[3]) begin
        check(32'(excTargetEl), 32'(rows[i].ctrl[5:4]));
      end
      if (rows[i].act[2]) begin
        @(posedge clk_sys);
        #1;
        check(32'(fetchStop), 32'h0000_0001);
        restart();
      end
      $display("row %0d done", i);
    end
    // status shows the pended halt beside the last action taken, an exception
    wb_rw(1'b0, OFS_STAT, 32'h0000_0000, rd);
    check(rd, 32'h0000_0012);
    // the pended halt converts once the debugger becomes trusted
    dbg_u.set_pins(1'b1, 1'b1);
    seen = 1'b0;
    for (int k = 0; k < 8 && !seen; k++) begin
      @(posedge clk_sys);
      #1;
      seen = (enterDebugState === 1'b1);
    end
    check(32'(seen), 32'h0000_0001);
    check(32'(eventPending), 32'h0000_0000);
    dbg_u.patch(BP_ADDR, 32'h1357_9bdf);
    fire(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, acts);
    check(32'(acts), 32'h0000_0000);
    dbg_u.unpatch(pa, po);
    check(pa, BP_ADDR);
    check(po, 32'h1357_9bdf);
    restart();
    curSecure <= 1'b0;
    $display("pend test done");
    // load hits, store and fetch do not
    wb_rw(1'b1, OFS_CTRL, 32'h0000_0002, rd);
    for (int k = 0; k < 3; k++) begin
      fire(1'b0, 1'b0, 1'b0, 1'b1, k == 1, k == 2, acts);
      check(32'(acts), k == 0 ? 32'h0000_0008 : 32'h0000_0000);
    end
    $display("watch test done");
    // step without exceptions is silent; with them it fires on the next instruction
    for (int k = 0; k < 4; k++) begin
      if (k == 0 || k == 2) begin
        wb_rw(1'b1, OFS_CTRL, k == 0 ? 32'h0000_0004 : 32'h0000_0006, rd);
      end
      fire(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, acts);
      check(32'(acts), k == 3 ? 32'h0000_0008 : 32'h0000_0000);
    end
    check(32'(dbg_u.haltsSeen), 32'h0000_0003);
    $display("step test done");
    report_and_stop();
  end
endmodule : debug_event_logic_bench
